//--- rtl/icp_top.sv
/*
  Configuration port of the device: sequencer with ready, done and
  mode sampling on sys_clk, and a write-only two-wire target on SCL.
  Assumes the configuration core checks the image and reports ok or
  error, and that the pad logic resolves SDA from sda_oe.
*/
`timescale 1ns/1ns
module icp_top
  import icp_pkg::*;
(
  // System clock and reset.
  input  wire logic      sys_clk,
  input  wire logic      rst_n,
  // Configuration pins.
  input  wire logic      config_restart_pulse_n,
  input  wire logic [2:0] mode_pins,
  input  wire logic      flash_target_pin,
  output logic           ready_o,
  output logic           done_o,
  // Two-wire link.
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe,
  // Configuration core side.
  input  wire logic      restart_pin_reused,
  input  wire logic      image_ok,
  input  wire logic      image_err,
  output icp_byte_t      cfg_byte,
  output logic           cfg_byte_valid,
  output logic           cfg_active
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address check against the target picked by the flash select.
  function automatic logic addr_hit(input logic [6:0] a, input logic fl);
    addr_hit = fl ? (a == ICP_ADDR_FLASH) : (a == ICP_ADDR_SRAM);
  endfunction

  // ----------------------------------------------------------------
  // System-domain synchronisers
  // ----------------------------------------------------------------
  logic       rst_s1_r, rst_s2_r, rst_d_r;  // Restart pin stages.
  logic [2:0] mode_s1_r, mode_s2_r;         // Mode pin stages.
  logic       fl_s1_r, fl_s2_r;             // Flash select stages.
  logic       bt_s1_r, bt_s2_r, bt_d_r;     // Byte toggle stages.
  logic       restart_fall;                 // Restart pulse seen.

  // Every pin passes two flops; the third stage only feeds the edge.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_s1_r  <= 1'b1;
      rst_s2_r  <= 1'b1;
      rst_d_r   <= 1'b1;
      mode_s1_r <= ICP_MODE_RST;
      mode_s2_r <= ICP_MODE_RST;
      fl_s1_r   <= 1'b0;
      fl_s2_r   <= 1'b0;
    end else begin
      rst_s1_r  <= config_restart_pulse_n;
      rst_s2_r  <= rst_s1_r;
      rst_d_r   <= rst_s2_r;
      mode_s1_r <= mode_pins;
      mode_s2_r <= mode_s1_r;
      fl_s1_r   <= flash_target_pin;
      fl_s2_r   <= fl_s1_r;
    end
  end

  // A reused restart pin is plain user logic and must not restart us.
  assign restart_fall = rst_d_r && !rst_s2_r && !restart_pin_reused;

  // ----------------------------------------------------------------
  // Configuration sequencer
  // ----------------------------------------------------------------
  icp_state_t state_r;                 // Sequencer state.
  logic [3:0] cnt_r;                   // Hold and pulse timer.
  logic [2:0] mode_r;                  // Mode latched at ready rise.
  logic       flash_r;                 // Target latched at ready rise.

  // Power-up and restart both begin in HOLD with ready and done low.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ICP_ST_HOLD;
      cnt_r   <= ICP_CNT_RST;
      mode_r  <= ICP_MODE_RST;
      flash_r <= 1'b0;
    end else if (restart_fall) begin
      state_r <= ICP_ST_HOLD;
      cnt_r   <= ICP_CNT_RST;
    end else begin
      case (state_r)
        ICP_ST_HOLD: begin
          if (cnt_r == 4'(ICP_HOLD_CYC - 1)) begin
            state_r <= ICP_ST_READY;
            cnt_r   <= ICP_CNT_RST;
            mode_r  <= mode_s2_r;
            flash_r <= fl_s2_r;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ICP_ST_READY: begin
          if (cnt_r == 4'(ICP_PULSE_CYC - 1)) begin
            cnt_r <= ICP_CNT_RST;
            // Only mode 100 with the restart pin kept opens the port.
            if (mode_r == ICP_MODE_I2C && !restart_pin_reused) begin
              state_r <= ICP_ST_LOAD;
            end else begin
              state_r <= ICP_ST_OFF;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ICP_ST_LOAD: begin
          // An error wins over ok: a bad image must never show done.
          if (image_err) begin
            state_r <= ICP_ST_FAIL;
          end else if (image_ok) begin
            state_r <= ICP_ST_DONE;
          end
        end
        ICP_ST_DONE, ICP_ST_FAIL, ICP_ST_OFF: begin
          state_r <= state_r;          // Wait for a restart.
        end
        default: begin
          state_r <= ICP_ST_HOLD;
        end
      endcase
    end
  end

  // Pins come straight from flops; next values follow the state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ready_o    <= 1'b0;
      done_o     <= 1'b0;
      cfg_active <= 1'b0;
    end else begin
      ready_o    <= (state_r == ICP_ST_HOLD && cnt_r == 4'(ICP_HOLD_CYC - 1) &&
                     !restart_fall) ||
                    (state_r == ICP_ST_READY && cnt_r != 4'(ICP_PULSE_CYC - 1) &&
                     !restart_fall);
      done_o     <= (done_o && !restart_fall) ||
                    (state_r == ICP_ST_LOAD && image_ok && !image_err &&
                     !restart_fall);
      cfg_active <= (state_r == ICP_ST_READY && cnt_r == 4'(ICP_PULSE_CYC - 1) &&
                     mode_r == ICP_MODE_I2C && !restart_pin_reused && !restart_fall) ||
                    (cfg_active && state_r == ICP_ST_LOAD && !image_ok && !image_err &&
                     !restart_fall);
    end
  end

  // ----------------------------------------------------------------
  // Link domain on SCL
  // ----------------------------------------------------------------
  logic       lr_s1_r, lr_s2_r;   // Reset carried onto SCL.
  logic       en_s1_r, en_s2_r;   // Loading allowed, carried onto SCL.
  logic       tf_s1_r, tf_s2_r;   // Target select, carried onto SCL.
  logic       start_tgl = 1'b0;   // Flips on every start condition.
  logic       stop_tgl = 1'b0;    // Flips on every stop condition.
  logic       stop_seen_r;        // Last stop taken by the link.
  logic       stop_pend;          // Stop seen, not yet taken.
  logic       start_ack_r;        // Last start taken by the link.
  logic       fresh_r;            // Next rising edge is a first bit.
  logic [3:0] bit_r;              // Bits received in this frame.
  logic [7:0] shift_r;            // Frame shift register.
  logic       addr_ph_r;          // Frame is the address frame.
  logic       sel_r;              // We are the addressed writer target.
  logic       tgt_fl_r;           // Address named the flash target.
  logic       byte_tgl_r;         // Flips once per accepted byte.
  icp_byte_t  byte_r;             // Last accepted byte.
  logic       start_pend;         // Start seen, not yet taken.
  logic       ack_ok;             // Frame deserves an ack.

  // SCL halts between frames, so a start is caught on SDA's own fall.
  // The start hold time keeps it stable until the next SCL fall.
  always_ff @(negedge sda_i) begin
    if (scl_i) begin
      start_tgl <= ~start_tgl;
    end
  end

  // A stop is caught on SDA's rise; without it, free SCL pulses after a
  // stop would be counted as a further byte for the old target.
  always_ff @(posedge sda_i) begin
    if (scl_i) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  assign start_pend = start_tgl != start_ack_r;
  assign stop_pend  = stop_tgl != stop_seen_r;
  // Reads return nack: readback of any kind is not offered.
  assign ack_ok = addr_ph_r ?
                  (addr_hit(shift_r[7:1], tf_s2_r) && !shift_r[0] && en_s2_r) :
                  (sel_r && en_s2_r);

  // Level crossings into the link domain, two flops each.
  always_ff @(posedge scl_i) begin
    lr_s1_r <= rst_n;
    lr_s2_r <= lr_s1_r;
    en_s1_r <= cfg_active;
    en_s2_r <= en_s1_r;
    tf_s1_r <= flash_r;
    tf_s2_r <= tf_s1_r;
  end

  // Rising edge: sample SDA, MSB first, and close each frame.
  always_ff @(posedge scl_i) begin
    if (!lr_s2_r) begin
      bit_r      <= ICP_CNT_RST;
      shift_r    <= 8'h00;
      addr_ph_r  <= 1'b1;
      sel_r      <= 1'b0;
      tgt_fl_r   <= 1'b0;
      byte_tgl_r <= 1'b0;
      byte_r     <= '0;
      stop_seen_r <= stop_tgl;
    end else if (fresh_r) begin
      // A start ends any transfer and also covers a stop just before it.
      bit_r       <= 4'h1;
      shift_r     <= {shift_r[6:0], sda_i};
      addr_ph_r   <= 1'b1;
      sel_r       <= 1'b0;
      stop_seen_r <= stop_tgl;
    end else if (stop_pend) begin
      // After a stop every bit is ignored until the next start.
      stop_seen_r <= stop_tgl;
      bit_r       <= ICP_CNT_RST;
      addr_ph_r   <= 1'b0;
      sel_r       <= 1'b0;
    end else if (bit_r == ICP_ACK_BIT) begin
      bit_r <= ICP_CNT_RST;
      if (addr_ph_r) begin
        addr_ph_r <= 1'b0;
        sel_r     <= ack_ok;
        tgt_fl_r  <= tf_s2_r;
      end else if (ack_ok) begin
        byte_r     <= '{flash: tgt_fl_r, data: shift_r};
        byte_tgl_r <= ~byte_tgl_r;
      end
    end else begin
      bit_r   <= bit_r + 4'h1;
      shift_r <= {shift_r[6:0], sda_i};
    end
  end

  // Falling edge: take starts and drive the ack in the low phase.
  always_ff @(negedge scl_i) begin
    if (!lr_s2_r) begin
      start_ack_r <= start_tgl;
      fresh_r     <= 1'b0;
      sda_oe      <= 1'b0;
      sda_o       <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      if (start_pend) begin
        start_ack_r <= start_tgl;
        fresh_r     <= 1'b1;
        sda_oe      <= 1'b0;
      end else begin
        fresh_r <= 1'b0;
        // Low before the ninth pulse, released at its falling edge.
        sda_oe  <= (bit_r == ICP_ACK_BIT) && !fresh_r && ack_ok;
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte hand-over into the system domain
  // ----------------------------------------------------------------
  // The byte stays put for nine SCL periods, far longer than the
  // three system cycles that the toggle needs to cross.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bt_s1_r        <= 1'b0;
      bt_s2_r        <= 1'b0;
      bt_d_r         <= 1'b0;
      cfg_byte       <= '0;
      cfg_byte_valid <= 1'b0;
    end else begin
      bt_s1_r        <= byte_tgl_r;
      bt_s2_r        <= bt_s1_r;
      bt_d_r         <= bt_s2_r;
      cfg_byte_valid <= (bt_s2_r != bt_d_r) && state_r == ICP_ST_LOAD;
      if ((bt_s2_r != bt_d_r) && state_r == ICP_ST_LOAD) begin
        cfg_byte <= byte_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ready_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ready_o) && !restart_fall |-> ready_o ##1 ready_o ##1 !ready_o)
    else $error("ready pulse length wrong");
  a_mode_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ready_o) |-> mode_r == $past(mode_s2_r) || $past(restart_fall))
    else $error("mode not sampled at ready rise");
  a_mode_enter: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ICP_ST_READY && cnt_r == 4'(ICP_PULSE_CYC - 1) && !restart_fall &&
    mode_r == ICP_MODE_I2C && !restart_pin_reused |=> state_r == ICP_ST_LOAD && cfg_active)
    else $error("mode 100 did not open the port");
  a_reuse_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ICP_ST_READY && restart_pin_reused |=> !cfg_active)
    else $error("port opened with restart pin reused");
  a_done_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done_o |-> ($past(done_o) && !$past(restart_fall)) ||
               ($past(state_r) == ICP_ST_LOAD && $past(image_ok) && !$past(image_err)))
    else $error("done high without success");
  a_restart_seq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    restart_fall |=> state_r == ICP_ST_HOLD && !done_o && !ready_o ##8 ready_o)
    else $error("restart did not rerun the sequence");
  a_byte_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_byte_valid |-> $past(state_r) == ICP_ST_LOAD)
    else $error("byte passed outside loading");
  a_ack_window: assert property (@(negedge scl_i) disable iff (!lr_s2_r)
    sda_oe |-> $past(bit_r) == ICP_ACK_BIT && bit_r == ICP_CNT_RST && !sda_o)
    else $error("SDA driven outside the ack bit");
  a_ack_release: assert property (@(negedge scl_i) disable iff (!lr_s2_r)
    sda_oe |=> !sda_oe)
    else $error("ack held past the ninth pulse");
  a_unmatched_quiet: assert property (@(posedge scl_i) disable iff (!lr_s2_r)
    !addr_ph_r && !sel_r && !fresh_r |=> $stable(byte_tgl_r))
    else $error("byte taken without a matching address");

  c_ready_rise: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(ready_o));
  c_loading:    cover property (@(posedge sys_clk) disable iff (!rst_n) cfg_byte_valid);
  c_done:       cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(done_o));
  c_ack:        cover property (@(negedge scl_i) disable iff (!lr_s2_r) sda_oe);

endmodule

//--- shared/icp_pkg.sv
/*
  Shared constants and types for the serial configuration port.
  Assumes it is compiled before any module that imports it.
*/
package icp_pkg;

  // ----------------------------------------------------------------
  // Mode pins and target addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] ICP_MODE_I2C    = 3'h4;  // Mode pins value 100.
  localparam logic [6:0] ICP_ADDR_SRAM   = 7'h50; // Volatile memory target.
  localparam logic [6:0] ICP_ADDR_FLASH  = 7'h58; // Embedded flash target.
  localparam logic [3:0] ICP_ACK_BIT     = 4'h8;  // Bit count of the ninth pulse.

  // ----------------------------------------------------------------
  // Sequencer counts and reset values
  // ----------------------------------------------------------------
  localparam int         ICP_HOLD_CYC    = 8;     // Ready low before the pulse.
  localparam int         ICP_PULSE_CYC   = 2;     // Ready high pulse length.
  localparam logic [2:0] ICP_MODE_RST    = 3'h7;  // Mode pins idle high.
  localparam logic [3:0] ICP_CNT_RST     = 4'h0;

  // State of the configuration sequencer.
  typedef enum logic [2:0] {
    ICP_ST_HOLD,
    ICP_ST_READY,
    ICP_ST_LOAD,
    ICP_ST_DONE,
    ICP_ST_FAIL,
    ICP_ST_OFF
  } icp_state_t;

  // One received bitstream byte and the memory it is meant for.
  typedef struct packed {
    logic       flash;
    logic [7:0] data;
  } icp_byte_t;

endpackage

//--- tb/icp_host_model.sv
/*
  Two-wire host model: drives SCL and its own side of SDA through tasks.
  Assumes the bench resolves the SDA wire with a pull-up and feeds the
  level back on sda_line.
*/
`timescale 1ns/1ns
module icp_host_model #(
  parameter int HALF = 15            // Half SCL period in ns.
) (
  // Resolved wire level.
  input  wire logic sda_line,
  // Host drives.
  output logic      scl,
  output logic      sda_drv
);
  // ----------------------------------------------------------------
  // Bus idle level
  // ----------------------------------------------------------------
  // SCL is driven high and SDA starts released, so the pull-up holds it high.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus primitives
  // ----------------------------------------------------------------
  // Pulses with SDA released; the link side needs them to see its reset.
  task automatic clocks(input int n);
    repeat (n) begin
      #HALF scl = 1'b0;
      #HALF scl = 1'b1;
    end
  endtask

  // Start: SDA falls while SCL stays high.
  task automatic start();
    sda_drv = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
  endtask

  // One bit: SDA moves only in the low phase and holds while SCL is high.
  // The small offset keeps the SDA change clear of the SCL fall.
  task automatic put_bit(input logic b, output logic seen);
    #4 sda_drv = b;
    #(HALF - 4) scl = 1'b1;
    #(HALF / 2) seen = sda_line;
    #(HALF - HALF / 2) scl = 1'b0;
  endtask

  // Eight bits MSB first, then SDA released for the ninth pulse.
  // The address byte carries the direction bit in bit 0.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], seen);
    end
    put_bit(1'b1, seen);
    ack = (seen === 1'b0);
  endtask

  // Read attempt: SDA stays released for eight bits, then the host
  // answers the last byte with a not-acknowledge before its stop.
  task automatic recv_byte(output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, seen);
      b[i] = seen;
    end
    put_bit(1'b1, seen);
  endtask

  // Stop: SDA rises while SCL is high, leaving the bus idle.
  task automatic stop();
    #4 sda_drv = 1'b0;
    #(HALF - 4) scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask
endmodule

//--- tb/tb_icp_top.sv
/*
  Self-checking bench for the configuration port: sequencer, mode
  sampling, and write-only target traffic through the host model.
  Assumes the package constants and the hand-over timing of icp_top.
*/
`timescale 1ns/1ns
module tb_icp_top;
  import icp_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       sys_clk, rst_n, config_restart_pulse_n, flash_target_pin;
  logic [2:0] mode_pins;
  logic       ready_o, done_o, scl, sda_drv, sda_o, sda_oe, sda_line;
  logic       restart_pin_reused, image_ok, image_err, cfg_byte_valid, cfg_active;
  icp_byte_t  cfg_byte;
  icp_byte_t  got_q[$];              // Bytes handed to the core.
  int         bad_count = 0;
  int         checks_done = 0;

  // Open-drain wire: either party may pull low, the pull-up wins otherwise.
  assign sda_line = (sda_oe ? sda_o : 1'b1) & sda_drv;

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  icp_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .config_restart_pulse_n(config_restart_pulse_n), .mode_pins(mode_pins),
    .flash_target_pin(flash_target_pin), .ready_o(ready_o), .done_o(done_o),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .restart_pin_reused(restart_pin_reused), .image_ok(image_ok),
    .image_err(image_err), .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
    .cfg_active(cfg_active));
  icp_host_model i_host (.sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  // Collect every accepted byte; the pulse stands one cycle only.
  always @(negedge sys_clk) begin
    if (cfg_byte_valid === 1'b1) begin
      got_q.push_back(cfg_byte);
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Waits for the ready pulse, measures it, then moves the mode pins away
  // so that a port which keeps sampling them would change its mind.
  task automatic seq_check(input logic exp_act);
    int n;
    int hi;
    n = 0;
    hi = 0;
    while (ready_o !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk("done in sequence", 9'h0, done_o);
    while (ready_o === 1'b1 && hi < 10) begin
      @(negedge sys_clk);
      hi++;
    end
    chk("ready pulse", 9'(ICP_PULSE_CYC), 9'(hi));
    mode_pins = ~mode_pins;
    repeat (3) @(negedge sys_clk);
    chk("port active", exp_act, cfg_active);
  endtask

  // A single low pulse on the restart pin, with new mode and target.
  task automatic restart(input logic [2:0] mode, input logic fl, input logic exp_act);
    @(negedge sys_clk);
    mode_pins = mode;
    flash_target_pin = fl;
    config_restart_pulse_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    config_restart_pulse_n = 1'b1;
    seq_check(exp_act);
  endtask

  // One frame: address byte, n data bytes counting up from d0, stop.
  task automatic frame(input logic [7:0] first, input logic [7:0] d0, input int n,
                       input logic exp_ack);
    logic ack;
    got_q.delete();
    i_host.clocks(3);
    i_host.start();
    i_host.send_byte(first, ack);
    chk("address ack", exp_ack, ack);
    for (int i = 0; i < n; i++) begin
      i_host.send_byte(d0 + 8'(i), ack);
      chk("data ack", exp_ack, ack);
    end
    i_host.stop();
    repeat (8) @(negedge sys_clk);
    chk("released after stop", 9'h0, sda_oe);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sram_write();
    frame({ICP_ADDR_SRAM, 1'b0}, 8'h1e, 2, 1'b1);
    chk("byte count", 9'h2, 9'(got_q.size()));
    chk("first byte", {1'b0, 8'h1e}, got_q[0]);
    chk("second byte", {1'b0, 8'h1f}, got_q[1]);
    // Free clocks after the stop must not make up another byte.
    i_host.clocks(9);
    repeat (8) @(negedge sys_clk);
    chk("bytes after stop", 9'h2, 9'(got_q.size()));
  endtask

  // Wrong target and read direction are both refused and deliver nothing.
  task automatic t_refusals();
    logic       ack;
    logic [7:0] rd;
    frame({ICP_ADDR_FLASH, 1'b0}, 8'h33, 1, 1'b0);
    chk("bytes after bad address", 9'h0, 9'(got_q.size()));
    frame({ICP_ADDR_SRAM, 1'b1}, 8'h00, 0, 1'b0);
    // Reading on past the refusal: the device must never drive a bit.
    i_host.start();
    i_host.send_byte({ICP_ADDR_SRAM, 1'b1}, ack);
    chk("read address ack", 9'h0, ack);
    i_host.recv_byte(rd);
    chk("read data", 9'h0ff, 9'(rd));
    i_host.stop();
  endtask

  task automatic t_image(input logic ok, input logic exp_done);
    @(negedge sys_clk);
    image_ok = ok;
    image_err = ~ok;
    @(negedge sys_clk);
    image_ok = 1'b0;
    image_err = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("done level", exp_done, done_o);
    chk("port closed", 9'h0, cfg_active);
  endtask

  task automatic t_flash();
    restart(ICP_MODE_I2C, 1'b1, 1'b1);
    frame({ICP_ADDR_FLASH, 1'b0}, 8'ha5, 1, 1'b1);
    chk("flash byte", {1'b1, 8'ha5}, got_q[0]);
  endtask

  // Another mode value keeps the port shut, so frames are refused.
  task automatic t_other_mode();
    restart(3'h5, 1'b0, 1'b0);
    frame({ICP_ADDR_SRAM, 1'b0}, 8'h11, 1, 1'b0);
  endtask

  // Reuse flagged during the ready pulse keeps the port shut; after that
  // a pulse on the reused pin must not start a sequence at all.
  task automatic t_reused();
    int hi;
    hi = 0;
    @(negedge sys_clk);
    mode_pins = ICP_MODE_I2C;
    config_restart_pulse_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    config_restart_pulse_n = 1'b1;
    while (ready_o !== 1'b1 && hi < 40) begin
      @(negedge sys_clk);
      hi++;
    end
    chk("ready before reuse", 9'h1, ready_o);
    restart_pin_reused = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("port after late reuse", 9'h0, cfg_active);
    hi = 0;
    config_restart_pulse_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    config_restart_pulse_n = 1'b1;
    repeat (30) begin
      @(negedge sys_clk);
      hi += (ready_o === 1'b1);
    end
    chk("ready while reused", 9'h0, 9'(hi));
    chk("port while reused", 9'h0, cfg_active);
    restart_pin_reused = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    config_restart_pulse_n = 1'b1;
    mode_pins = ICP_MODE_I2C;
    flash_target_pin = 1'b0;
    restart_pin_reused = 1'b0;
    image_ok = 1'b0;
    image_err = 1'b0;
    i_host.clocks(4);
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    seq_check(1'b1);
    t_sram_write();
    t_refusals();
    t_image(1'b1, 1'b1);
    t_flash();
    t_image(1'b0, 1'b0);
    t_other_mode();
    t_reused();
    report_and_stop();
  end

  // The tests need well under 20 us; this limit leaves ample margin.
  initial begin
    #400000;
    bad_count++;
    $display("Watchdog expired");
    report_and_stop();
  end
endmodule
